// ---- tcm_timer_top.sv ----
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
// How it works
// - Mode 0: 5-bit prescaler then 8-bit count
// - Mode 1: low and high chained, 16 bits
// - Mode 2: overflow reloads low from high
// - Vector acknowledge clears timer overflow flag
// - Mode 3: low byte uses timer 0 controls
// - Mode 3: high byte counts, timer 1 run/flag
// - Timer 1 in mode 3 holds its count
// - Gate set: count only while pin high
// - Source bit picks clock or count pin
// - Wrap to zero sets overflow flag, except timer 1 when timer 0 is in mode 3
// - Run bits written by software only
// - Timer 1 flags at bits 7,6,3,2
// - External flag set; edge flag cleared on acknowledge
// - Type 1 falling edge, 0 low level
// - Timer 0 flags at bits 5,4,1,0
// - Timer mode counts every twelve clocks
// - Counter mode counts sampled falling edges
module tcm_timer_top (
    input  logic        ref_clk,
    input  logic        rst_n,
    input  logic        wb_cyc_i,
    input  logic        wb_stb_i,
    input  logic        wb_we_i,
    input  logic [9:0]  wb_adr_i,
    input  logic [3:0]  wb_sel_i,
    input  logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic        wb_ack_o,
    input  logic        extIrq0Pin,
    input  logic        extIrq1Pin,
    input  logic        t0CountPin,
    input  logic        t1CountPin,
    input  logic [3:0]  irqAck,
    output logic [3:0]  irqReq
);
    typedef struct packed {
        logic [3:0]  div;
        logic        tick;
        logic [7:0]  ctrl;
        logic [7:0]  mode;
        logic [7:0]  t0CountLow;
        logic [7:0]  t0CountHigh;
        logic [7:0]  t1CountLow;
        logic [7:0]  t1CountHigh;
        logic        ack;
        logic [31:0] dat;
    } tcm_top_s;

    localparam tcm_top_s TOP_RESET = '{
        div:         4'h0,
        tick:        1'b0,
        ctrl:        tcm_pkg::CTRL_RESET,
        mode:        tcm_pkg::MODE_RESET,
        t0CountLow:  tcm_pkg::COUNT_RESET,
        t0CountHigh: tcm_pkg::COUNT_RESET,
        t1CountLow:  tcm_pkg::COUNT_RESET,
        t1CountHigh: tcm_pkg::COUNT_RESET,
        ack:         1'b0,
        dat:         32'h0000_0000
    };

    logic [1:0]  rstSync;
    logic        rstLocalN;
    tcm_top_s    s_r;
    tcm_top_s    s_nxt;
    logic [3:0]  pinSync;
    logic [3:0]  pinLevel;
    logic [3:0]  pinFell;
    logic        req;
    logic        mapped;
    logic [7:0]  idx;
    logic        wrNow;
    logic [1:0]  t0Mode;
    logic [1:0]  t1Mode;
    logic        t0Split;
    logic        run0;
    logic        run1;
    logic        inc0;
    logic        inc1;
    logic        incHigh0;
    logic [16:0] step0;
    logic [16:0] step1;
    logic        ovf0;
    logic        ovf1;
    logic        ovfHigh0;

    // Reset is released synchronously so no flop leaves reset on a split edge
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstLocalN = rstSync[1];

    tcm_pin_sync u_sync (
        .ref_clk (ref_clk),
        .rstN    (rstLocalN),
        .pinIn   ({t1CountPin, t0CountPin, extIrq1Pin, extIrq0Pin}),
        .pinSync (pinSync)
    );

    tcm_pin_sampler u_samp (
        .ref_clk (ref_clk),
        .rstN    (rstLocalN),
        .tick    (s_r.tick),
        .pinSync (pinSync),
        .level   (pinLevel),
        .fell    (pinFell)
    );

    // One increment step; bit 16 flags the wrap to zero
    function automatic logic [16:0] stepTimer(input logic [1:0] m,
                                              input logic [7:0] lo,
                                              input logic [7:0] hi);
        logic [16:0] r;
        r = {1'b0, hi, lo};
        unique case (m)
            tcm_pkg::MODE_13BIT: begin
                r[4:0] = lo[4:0] + 5'h01;
                if (lo[4:0] == 5'h1f) begin
                    r[15:8] = hi + 8'h01;
                    r[16]   = (hi == 8'hff);
                end
            end
            tcm_pkg::MODE_16BIT: begin
                r = {1'b0, hi, lo} + 17'h0_0001;
            end
            tcm_pkg::MODE_RELOAD: begin
                r[7:0] = lo + 8'h01;
                if (lo == 8'hff) begin
                    r[7:0] = hi;
                    r[16]  = 1'b1;
                end
            end
            tcm_pkg::MODE_SPLIT: begin
                r[7:0] = lo + 8'h01;
                r[16]  = (lo == 8'hff);
            end
        endcase
        return r;
    endfunction : stepTimer

    assign req    = wb_cyc_i & wb_stb_i;
    assign mapped = (wb_adr_i[1:0] == 2'h0);
    assign idx    = wb_adr_i[9:2];
    // A write lands on the edge where the master sees ack
    assign wrNow  = req & wb_we_i & s_r.ack & wb_sel_i[0] & mapped;

    assign t0Mode  = s_r.mode[tcm_pkg::MODE0_HI:tcm_pkg::MODE0_LO];
    assign t1Mode  = s_r.mode[tcm_pkg::MODE1_HI:tcm_pkg::MODE1_LO];
    assign t0Split = (t0Mode == tcm_pkg::MODE_SPLIT);

    // Pin is active low, but the gate counts while it is high
    assign run0 = s_r.ctrl[tcm_pkg::TR0] &
                  (!s_r.mode[tcm_pkg::T0_GATE_BIT] | pinLevel[tcm_pkg::PIN_EXT0]);
    // With timer 0 split, timer 1 loses its run bit and runs unless halted or gated
    assign run1 = (t0Split | s_r.ctrl[tcm_pkg::TR1]) &
                  (!s_r.mode[tcm_pkg::T1_GATE_BIT] | pinLevel[tcm_pkg::PIN_EXT1]);

    assign inc0 = s_r.tick & run0 &
                  (!s_r.mode[tcm_pkg::SRC0] | pinFell[tcm_pkg::PIN_CNT0]);
    assign inc1 = s_r.tick & run1 & (t1Mode != tcm_pkg::MODE_SPLIT) &
                  (!s_r.mode[tcm_pkg::SRC1] | pinFell[tcm_pkg::PIN_CNT1]);
    assign incHigh0 = s_r.tick & t0Split & s_r.ctrl[tcm_pkg::TR1];

    assign step0    = stepTimer(t0Mode, s_r.t0CountLow, s_r.t0CountHigh);
    assign step1    = stepTimer(t1Mode, s_r.t1CountLow, s_r.t1CountHigh);
    assign ovf0     = inc0 & step0[16];
    // Timer 1 has no flag of its own while timer 0 is split
    assign ovf1     = inc1 & step1[16] & !t0Split;
    assign ovfHigh0 = incHigh0 & (s_r.t0CountHigh == 8'hff);

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = (s_r.div == tcm_pkg::DIV_LAST);
        s_nxt.div  = (s_r.div == tcm_pkg::DIV_LAST) ? 4'h0 : s_r.div + 4'h1;

        if (inc0) begin
            s_nxt.t0CountLow = step0[7:0];
            if (!t0Split) begin
                s_nxt.t0CountHigh = step0[15:8];
            end
        end
        if (incHigh0) begin
            s_nxt.t0CountHigh = s_r.t0CountHigh + 8'h01;
        end
        if (inc1) begin
            s_nxt.t1CountLow  = step1[7:0];
            s_nxt.t1CountHigh = step1[15:8];
        end

        // Software writes override a same-cycle count step
        if (wrNow) begin
            unique case (idx)
                tcm_pkg::IDX_CTRL: s_nxt.ctrl        = wb_dat_i[7:0];
                tcm_pkg::IDX_MODE: s_nxt.mode        = wb_dat_i[7:0];
                tcm_pkg::IDX_TL0:  s_nxt.t0CountLow  = wb_dat_i[7:0];
                tcm_pkg::IDX_TH0:  s_nxt.t0CountHigh = wb_dat_i[7:0];
                tcm_pkg::IDX_TL1:  s_nxt.t1CountLow  = wb_dat_i[7:0];
                tcm_pkg::IDX_TH1:  s_nxt.t1CountHigh = wb_dat_i[7:0];
                default: ;
            endcase
        end

        if (irqAck[tcm_pkg::IRQ_T0]) begin
            s_nxt.ctrl[tcm_pkg::TF0] = 1'b0;
        end
        if (irqAck[tcm_pkg::IRQ_T1]) begin
            s_nxt.ctrl[tcm_pkg::TF1] = 1'b0;
        end
        if (irqAck[tcm_pkg::IRQ_EXT0] & s_r.ctrl[tcm_pkg::IT0]) begin
            s_nxt.ctrl[tcm_pkg::IE0] = 1'b0;
        end
        if (irqAck[tcm_pkg::IRQ_EXT1] & s_r.ctrl[tcm_pkg::IT1]) begin
            s_nxt.ctrl[tcm_pkg::IE1] = 1'b0;
        end

        // Hardware sets come last so an event beats a same-cycle clear
        if (ovf0) begin
            s_nxt.ctrl[tcm_pkg::TF0] = 1'b1;
        end
        if (ovf1 | ovfHigh0) begin
            s_nxt.ctrl[tcm_pkg::TF1] = 1'b1;
        end
        if (s_r.tick) begin
            if (s_r.ctrl[tcm_pkg::IT0]) begin
                if (pinFell[tcm_pkg::PIN_EXT0]) begin
                    s_nxt.ctrl[tcm_pkg::IE0] = 1'b1;
                end
            end else begin
                s_nxt.ctrl[tcm_pkg::IE0] = !pinLevel[tcm_pkg::PIN_EXT0];
            end
            if (s_r.ctrl[tcm_pkg::IT1]) begin
                if (pinFell[tcm_pkg::PIN_EXT1]) begin
                    s_nxt.ctrl[tcm_pkg::IE1] = 1'b1;
                end
            end else begin
                s_nxt.ctrl[tcm_pkg::IE1] = !pinLevel[tcm_pkg::PIN_EXT1];
            end
        end

        // Fixed one-cycle answer; unmapped reads return zero
        s_nxt.ack = req & !s_r.ack;
        if (req & !s_r.ack) begin
            s_nxt.dat = 32'h0000_0000;
            if (mapped) begin
                unique case (idx)
                    tcm_pkg::IDX_CTRL: s_nxt.dat[7:0] = s_r.ctrl;
                    tcm_pkg::IDX_MODE: s_nxt.dat[7:0] = s_r.mode;
                    tcm_pkg::IDX_TL0:  s_nxt.dat[7:0] = s_r.t0CountLow;
                    tcm_pkg::IDX_TH0:  s_nxt.dat[7:0] = s_r.t0CountHigh;
                    tcm_pkg::IDX_TL1:  s_nxt.dat[7:0] = s_r.t1CountLow;
                    tcm_pkg::IDX_TH1:  s_nxt.dat[7:0] = s_r.t1CountHigh;
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstLocalN) begin
        if (!rstLocalN) begin
            s_r <= TOP_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.dat;
    assign wb_ack_o = s_r.ack;
    assign irqReq   = {s_r.ctrl[tcm_pkg::TF1], s_r.ctrl[tcm_pkg::IE1],
                       s_r.ctrl[tcm_pkg::TF0], s_r.ctrl[tcm_pkg::IE0]};

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstLocalN);

    property p_tick_period;
        s_r.tick |-> ##12 s_r.tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

    property p_tick_gap;
        s_r.tick |=> !s_r.tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

    property p_ack_next;
        (req && !s_r.ack) |=> (wb_ack_o ##1 !wb_ack_o);
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("bus answer late");

    property p_prescale_carry;
        (inc0 && t0Mode == tcm_pkg::MODE_13BIT && s_r.t0CountLow[4:0] == 5'h1f && !wrNow)
            |=> (s_r.t0CountHigh == $past(s_r.t0CountHigh) + 8'h01
                 && s_r.t0CountLow[4:0] == 5'h00);
    endproperty
    a_prescale_carry: assert property (p_prescale_carry) else $error("prescale carry lost");

    property p_cascade;
        (inc0 && t0Mode == tcm_pkg::MODE_16BIT && s_r.t0CountLow == 8'hff && !wrNow)
            |=> (s_r.t0CountLow == 8'h00
                 && s_r.t0CountHigh == $past(s_r.t0CountHigh) + 8'h01);
    endproperty
    a_cascade: assert property (p_cascade) else $error("16-bit carry lost");

    property p_reload;
        (inc0 && t0Mode == tcm_pkg::MODE_RELOAD && s_r.t0CountLow == 8'hff && !wrNow)
            |=> (s_r.t0CountLow == $past(s_r.t0CountHigh) && $stable(s_r.t0CountHigh)
                 && s_r.ctrl[tcm_pkg::TF0]);
    endproperty
    a_reload: assert property (p_reload) else $error("reload wrong");

    property p_split_high;
        (incHigh0 && s_r.t0CountHigh == 8'hff && !wrNow) |=> s_r.ctrl[tcm_pkg::TF1];
    endproperty
    a_split_high: assert property (p_split_high) else $error("split high flag missing");

    property p_halt1;
        (t1Mode == tcm_pkg::MODE_SPLIT && !wrNow)
            |=> ($stable(s_r.t1CountLow) && $stable(s_r.t1CountHigh));
    endproperty
    a_halt1: assert property (p_halt1) else $error("timer 1 moved while halted");

    property p_stopped0;
        (!s_r.ctrl[tcm_pkg::TR0] && !wrNow) |=> $stable(s_r.t0CountLow);
    endproperty
    a_stopped0: assert property (p_stopped0) else $error("timer 0 ran while off");

    property p_ack_clear;
        (irqAck[tcm_pkg::IRQ_T0] && !ovf0) |=> !irqReq[tcm_pkg::IRQ_T0];
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("flag not cleared");

    property p_ext_edge;
        (s_r.tick && s_r.ctrl[tcm_pkg::IT0] && pinFell[tcm_pkg::PIN_EXT0])
            |=> irqReq[tcm_pkg::IRQ_EXT0];
    endproperty
    a_ext_edge: assert property (p_ext_edge) else $error("edge flag missing");

    property p_ovf_flag;
        ovf0 |=> irqReq[tcm_pkg::IRQ_T0];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");

    c_reload:   cover property (inc0 && t0Mode == tcm_pkg::MODE_RELOAD && step0[16]);
    c_split:    cover property (ovfHigh0);
    c_ext_edge: cover property (s_r.tick && pinFell[tcm_pkg::PIN_EXT1] && s_r.ctrl[tcm_pkg::IT1]);
    c_read:     cover property (wb_ack_o && !wb_we_i && wb_dat_o != 32'h0);
endmodule : tcm_timer_top

// ---- tcm_pkg.sv ----
package tcm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CTRL = 8'h88;
    localparam logic [7:0] IDX_MODE = 8'h89;
    localparam logic [7:0] IDX_TL0  = 8'h8a;
    localparam logic [7:0] IDX_TL1  = 8'h8b;
    localparam logic [7:0] IDX_TH0  = 8'h8c;
    localparam logic [7:0] IDX_TH1  = 8'h8d;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;

    // Control register bit positions
    localparam int TF1 = 7;
    localparam int TR1 = 6;
    localparam int TF0 = 5;
    localparam int TR0 = 4;
    localparam int IE1 = 3;
    localparam int IT1 = 2;
    localparam int IE0 = 1;
    localparam int IT0 = 0;

    // Mode register field positions
    localparam int T1_GATE_BIT   = 7;
    localparam int SRC1    = 6;
    localparam int MODE1_HI = 5;
    localparam int MODE1_LO = 4;
    localparam int T0_GATE_BIT   = 3;
    localparam int SRC0    = 2;
    localparam int MODE0_HI = 1;
    localparam int MODE0_LO = 0;

    localparam logic [1:0] MODE_13BIT  = 2'h0;
    localparam logic [1:0] MODE_16BIT  = 2'h1;
    localparam logic [1:0] MODE_RELOAD = 2'h2;
    localparam logic [1:0] MODE_SPLIT  = 2'h3;

    // Interrupt request / acknowledge lanes
    localparam int IRQ_EXT0 = 0;
    localparam int IRQ_T0   = 1;
    localparam int IRQ_EXT1 = 2;
    localparam int IRQ_T1   = 3;

    // Pin lanes after synchronising
    localparam int PIN_EXT0 = 0;
    localparam int PIN_EXT1 = 1;
    localparam int PIN_CNT0 = 2;
    localparam int PIN_CNT1 = 3;
    localparam logic [3:0] PIN_IDLE = 4'hf;

    // One peripheral cycle is twelve oscillator clocks
    localparam int         PCYCLE_CLKS = 12;
    localparam logic [3:0] DIV_LAST    = 4'(PCYCLE_CLKS - 1);
endpackage : tcm_pkg

// ---- tcm_pin_sync.sv ----
`timescale 1ns/10ps
module tcm_pin_sync (
    input  logic       ref_clk,
    input  logic       rstN,
    input  logic [3:0] pinIn,
    output logic [3:0] pinSync
);
    typedef struct packed {
        logic [3:0] stage1;
        logic [3:0] stage2;
    } tcm_sync_s;

    tcm_sync_s s_r;
    tcm_sync_s s_nxt;

    // First stage feeds the second stage only
    always_comb begin
        s_nxt = s_r;
        s_nxt.stage1 = pinIn;
        s_nxt.stage2 = s_r.stage1;
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_r <= {tcm_pkg::PIN_IDLE, tcm_pkg::PIN_IDLE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pinSync = s_r.stage2;
endmodule : tcm_pin_sync

// ---- tcm_pin_sampler.sv ----
`timescale 1ns/10ps
module tcm_pin_sampler (
    input  logic       ref_clk,
    input  logic       rstN,
    input  logic       tick,
    input  logic [3:0] pinSync,
    output logic [3:0] level,
    output logic [3:0] fell
);
    typedef struct packed {
        logic [3:0] level;
        logic [3:0] fell;
    } tcm_samp_s;

    tcm_samp_s s_r;
    tcm_samp_s s_nxt;

    // Sampled once per peripheral cycle; a fall is held for one whole cycle
    always_comb begin
        s_nxt = s_r;
        for (int i = 0; i < 4; i++) begin
            if (tick) begin
                s_nxt.level[i] = pinSync[i];
                s_nxt.fell[i]  = s_r.level[i] & !pinSync[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstN) begin
        if (!rstN) begin
            s_r <= {tcm_pkg::PIN_IDLE, 4'h0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level;
    assign fell  = s_r.fell;
endmodule : tcm_pin_sampler

// ---- tcm_far_model.sv ----
`timescale 1ns/10ps
module tcm_far_model (
    input  logic       ref_clk,
    input  logic [3:0] irqReq,
    output logic [3:0] irqAck,
    output logic       extIrq0Pin,
    output logic       extIrq1Pin,
    output logic       t0CountPin,
    output logic       t1CountPin
);
    logic       ackEn;
    logic [3:0] ackOnce;

    initial begin
        irqAck     = 4'h0;
        ackOnce    = 4'h0;
        ackEn      = 1'b1;
        extIrq0Pin = 1'b1;
        extIrq1Pin = 1'b1;
        t0CountPin = 1'b1;
        t1CountPin = 1'b1;
    end

    // Random stall models a processor that vectors late
    always @(posedge ref_clk) begin
        for (int i = 0; i < 4; i++) begin
            irqAck[i] <= ackOnce[i] || (ackEn && irqReq[i] && !irqAck[i] && ($urandom % 3 == 0));
        end
    end

    task automatic ack_once(input int lane);
        @(posedge ref_clk);
        ackOnce[lane] <= 1'b1;
        @(posedge ref_clk);
        ackOnce[lane] <= 1'b0;
    endtask : ack_once

    // Each level held two peripheral cycles so every sample sees it
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            if (idx == 0) t0CountPin <= 1'b0; else t1CountPin <= 1'b0;
            repeat (24) @(posedge ref_clk);
            if (idx == 0) t0CountPin <= 1'b1; else t1CountPin <= 1'b1;
            repeat (23) @(posedge ref_clk);
        end
    endtask : pulse

    task automatic set_ext(input int idx, input logic lvl);
        @(posedge ref_clk);
        if (idx == 0) extIrq0Pin <= lvl; else extIrq1Pin <= lvl;
    endtask : set_ext
endmodule : tcm_far_model

// ---- testbench.sv ----
`timescale 1ns/10ps
module testbench;
    logic        ref_clk;
    logic        rst_n;
    logic        wbCyc;
    logic        wbStb;
    logic        wbWe;
    logic [9:0]  wbAdr;
    logic [3:0]  wbSel;
    logic [31:0] wbDatW;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic        ext0;
    logic        ext1;
    logic        cnt0;
    logic        cnt1;
    logic [3:0]  irqAck;
    logic [3:0]  irqReq;
    logic [31:0] rdQ [$];
    logic [31:0] perQ [$];
    logic [31:0] cycCnt;
    logic [31:0] lastRise;
    logic        reqPrev;
    logic [7:0]  regs [6];
    logic [7:0]  p;
    int          watchLane;
    int          errorCnt;
    int          compares;

    tcm_timer_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .extIrq0Pin(ext0), .extIrq1Pin(ext1),
        .t0CountPin(cnt0), .t1CountPin(cnt1), .irqAck(irqAck), .irqReq(irqReq));

    tcm_far_model farSide (.ref_clk(ref_clk), .irqReq(irqReq), .irqAck(irqAck),
        .extIrq0Pin(ext0), .extIrq1Pin(ext1), .t0CountPin(cnt0), .t1CountPin(cnt1));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", compares, errorCnt);
        if (errorCnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic bus(input logic [7:0] idx, input logic we, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= {idx, 2'b00};
        wbDatW <= {24'h000000, d};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        if (n >= 20) check("bus ack", 32'h0, 32'h1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        rdQ.push_back({24'h000000, exp});
        bus(idx, 1'b0, 8'h00);
    endtask : rd

    task automatic wait_rise(input int lane);
        int n;
        n = 0;
        while (irqReq[lane] !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            n++;
        end
        while (irqReq[lane] !== 1'b1 && n < 9000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 9000) check("overflow seen", 32'h0, 32'h1);
        @(posedge ref_clk);
    endtask : wait_rise

    task automatic wait_clk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_clk

    // Watches read data and the spacing of overflow requests
    always @(posedge ref_clk) begin
        cycCnt = cycCnt + 1;
        if (wbAck === 1'b1 && wbWe === 1'b0 && rdQ.size() > 0) check("read data", wbDatR, rdQ.pop_front());
        if (irqReq[watchLane] === 1'b1 && reqPrev === 1'b0) begin
            if (perQ.size() > 0) check("overflow period", cycCnt - lastRise, perQ.pop_front());
            lastRise = cycCnt;
        end
        reqPrev = irqReq[watchLane];
    end

    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        wait_clk(60000);
        check("watchdog", 32'h0, 32'h1);
        give_verdict();
    end

    initial begin
        {rst_n, wbCyc, wbStb, wbWe, wbAdr, wbDatW, cycCnt, lastRise, reqPrev} = '0;
        wbSel = 4'hf;
        watchLane = 0;
        errorCnt = 0;
        compares = 0;
        regs = '{tcm_pkg::IDX_CTRL, tcm_pkg::IDX_MODE, tcm_pkg::IDX_TL0, tcm_pkg::IDX_TL1,
            tcm_pkg::IDX_TH0, tcm_pkg::IDX_TH1};
        void'($urandom(29));
        wait_clk(4);
        rst_n <= 1'b1;
        wait_clk(4);
        for (int i = 0; i < 6; i++) rd(regs[i], 8'h00);
        rd(8'h8e, 8'h00);
        wr(8'h8e, 8'h5a);
        rd(8'h8e, 8'h00);
        for (int i = 1; i < 6; i++) begin
            p = 8'($urandom);
            wr(regs[i], p);
            rd(regs[i], p);
        end
        wr(regs[1], 8'h00);
        $display("Test registers done");
        farSide.ackEn <= 1'b0;
        for (int e = 0; e < 2; e++) begin
            wr(regs[0], 8'(1 << (e ? tcm_pkg::IT1 : tcm_pkg::IT0)));
            farSide.set_ext(e, 1'b0);
            wait_clk(40);
            check("request lanes", {28'h0, irqReq}, 32'(1 << (2 * e)));
            rd(regs[0], 8'(3 << (e ? tcm_pkg::IT1 : tcm_pkg::IT0)));
            farSide.ack_once(2 * e);
            wait_clk(3);
            check("edge flag after ack", {31'h0, irqReq[2 * e]}, 32'h0);
            farSide.set_ext(e, 1'b1);
            wr(regs[0], 8'h00);
            wait_clk(40);
            farSide.set_ext(e, 1'b0);
            wait_clk(40);
            farSide.ack_once(2 * e);
            wait_clk(3);
            rd(regs[0], 8'(2 << (e ? tcm_pkg::IT1 : tcm_pkg::IT0)));
            farSide.set_ext(e, 1'b1);
            wait_clk(40);
            rd(regs[0], 8'h00);
        end
        farSide.ackEn <= 1'b1;
        $display("Test external flags done");
        for (int t = 0; t < 2; t++) begin
            p = 8'(1 + $urandom % 8);
            wr(regs[2 + t], 8'h00);
            wr(regs[4 + t], 8'h00);
            wr(regs[1], 8'(8'h0d << (4 * t)));
            wr(regs[0], 8'(1 << (t ? tcm_pkg::TR1 : tcm_pkg::TR0)));
            farSide.set_ext(t, 1'b0);
            wait_clk(40);
            farSide.pulse(t, 3);
            wait_clk(40);
            farSide.set_ext(t, 1'b1);
            wait_clk(40);
            farSide.pulse(t, p);
            wait_clk(60);
            wr(regs[0], 8'h00);
            rd(regs[2 + t], p);
            rd(regs[4 + t], 8'h00);
        end
        $display("Test counter and gate done");
        // Gate clear must ignore the low pins
        farSide.set_ext(0, 1'b0);
        farSide.set_ext(1, 1'b0);
        for (int t = 0; t < 2; t++) begin
            for (int m = 0; m < 3; m++) begin
                p = (m == 2) ? 8'(8'he0 + $urandom % 15) : 8'hff;
                watchLane = t ? tcm_pkg::IRQ_T1 : tcm_pkg::IRQ_T0;
                wr(regs[2 + t], 8'hff);
                wr(regs[4 + t], p);
                wr(regs[1], 8'(m << (4 * t)));
                wr(regs[0], 8'(1 << (t ? tcm_pkg::TR1 : tcm_pkg::TR0)));
                wait_rise(watchLane);
                perQ.push_back(32'(12 * (m == 0 ? 32 : (m == 1 ? 256 : 1)) * (256 - p)));
                wr(regs[4 + t], p);
                wait_rise(watchLane);
                wr(regs[0], 8'h00);
                $display("Test mode %0d timer %0d done", m, t);
            end
        end
        farSide.set_ext(0, 1'b1);
        farSide.set_ext(1, 1'b1);
        watchLane = tcm_pkg::IRQ_T1;
        p = 8'(8'he0 + $urandom % 15);
        wr(regs[2], 8'h12);
        wr(regs[3], 8'h55);
        wr(regs[4], 8'hff);
        wr(regs[1], 8'h33);
        wr(regs[0], 8'(1 << tcm_pkg::TR1));
        wait_rise(watchLane);
        perQ.push_back(32'(12 * (256 - p)));
        wr(regs[4], p);
        wait_rise(watchLane);
        wr(regs[0], 8'h00);
        rd(regs[3], 8'h55);
        rd(regs[2], 8'h12);
        $display("Test split mode done");
        give_verdict();
    end
endmodule : testbench
